// ===== rtl/axis_cal_regs.svh
// Purpose: Address map, field positions and constants of the calibration bank
// Assumes: Byte-wide register port, 7-bit address
// Notes: Definitions only
`ifndef AXIS_CAL_REGS_SVH
`define AXIS_CAL_REGS_SVH

// ********************************************
// Register addresses
// ********************************************
`define ADDR_X_OFFSET_LOW 7'h21
`define ADDR_X_OFFSET_HIGH_GAIN_MSB 7'h22
`define ADDR_Y_OFFSET_LOW 7'h23
`define ADDR_Y_OFFSET_HIGH_GAIN_MSB 7'h24
`define ADDR_Z_OFFSET_LOW 7'h25
`define ADDR_Z_OFFSET_HIGH_GAIN_MSB 7'h26
`define ADDR_X_GAIN_LOW 7'h27
`define ADDR_Y_GAIN_LOW 7'h28
`define ADDR_Z_GAIN_LOW 7'h29
`define ADDR_PART_IDENTIFIER 7'h3B

// ********************************************
// Field layout and widths
// ********************************************
`define OFFSET_WIDTH 15
`define GAIN_WIDTH 9
`define GAIN_MSB_BIT 7
`define GAIN_UNITY 9'h100
`define GAIN_SHIFT 8
`define PART_ID_FACTORY_LSB 1
`define PART_ID_FACTORY_MSB 3
// Fixed pattern of the identifier, factory bits shown as zero (arbitrary)
`define PART_ID_FIXED 8'h00
`define UNMAPPED_READ 8'h00

`endif

// ===== rtl/axis_cal_pkg.sv
// Purpose: Shared types of the calibration bank
// Assumes: Three axes, 16-bit corrected results
// Notes: Constants live in axis_cal_regs.svh
package axis_cal_pkg;
  // Calibration of one axis
  typedef struct packed {
    logic [14:0] offset;
    logic [8:0] gain;
  } axis_cal_t;
  // One raw or corrected triplet
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } axis_triplet_t;
  // Register port write strobe with data
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } reg_wr_t;
  // Corrector sequencing
  typedef enum logic [1:0] {
    IDLE_ST = 2'b00,
    CALC_ST = 2'b01,
    SAVE_ST = 2'b11
  } corr_state_t;
endpackage

// ===== rtl/axis_corrector.sv
// Purpose: Gain and offset correction of one axis sample
// Assumes: Gain 0x100 is unity, saturating 16-bit result
// Notes: Purely combinational, registered by the caller
`timescale 1ns/1ns
`default_nettype none
`include "axis_cal_regs.svh"
module axis_corrector (
  input wire logic [15:0] sample_i,
  input wire axis_cal_pkg::axis_cal_t cal_i,
  output logic [15:0] result_o
);
  import axis_cal_pkg::*;

  // Wide intermediates avoid overflow before clamping
  logic signed [26:0] scaled;
  logic signed [26:0] summed;

  // ********************************************
  // Scale first, then add offset
  // ********************************************
  always_comb begin
    // Gain is unsigned, so extend with a zero sign bit
    scaled = 27'(($signed(sample_i) * $signed({1'b0, cal_i.gain}))
      >>> `GAIN_SHIFT);
    summed = scaled + 27'($signed(cal_i.offset));
    // Clamp rather than wrap, a wrapped sign flips the reading
    if (summed > 27'sd32767) begin
      result_o = 16'h7FFF;
    end else if (summed < -27'sd32768) begin
      result_o = 16'h8000;
    end else begin
      result_o = summed[15:0];
    end
  end
endmodule
`default_nettype wire

// ===== rtl/axis_cal_bank.sv
// Purpose: Register write port and per-axis storage
// Assumes: Factory values arrive on trim inputs, latched after reset
// Notes: Write-only locations, nothing read back here
`timescale 1ns/1ns
`default_nettype none
`include "axis_cal_regs.svh"
module axis_cal_bank (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire axis_cal_pkg::reg_wr_t wr_i,
  input wire axis_cal_pkg::axis_cal_t [2:0] trim_i,
  output axis_cal_pkg::axis_cal_t [2:0] cal_o
);
  import axis_cal_pkg::*;

  // Reset seen last cycle, used to capture trims at release
  logic rst_seen;

  always_ff @(posedge sys_clk_i) begin
    rst_seen <= srst_i;
  end

  // ********************************************
  // One storage slice per axis
  // ********************************************
  genvar ax;
  generate
    for (ax = 0; ax < 3; ax++) begin : g_axis
      // Axis addresses step by two; gain lows step by one
      localparam logic [6:0] LOW_A = 7'(`ADDR_X_OFFSET_LOW + 2 * ax);
      localparam logic [6:0] HIGH_A =
        7'(`ADDR_X_OFFSET_HIGH_GAIN_MSB + 2 * ax);
      localparam logic [6:0] GAIN_A = 7'(`ADDR_X_GAIN_LOW + ax);
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          // Constant while in reset; trims are taken at release
          cal_o[ax] <= '0;
        end else if (rst_seen) begin
          cal_o[ax] <= trim_i[ax];
        end else if (wr_i.en) begin
          // Software overrides the factory values
          if (wr_i.addr == LOW_A) begin
            cal_o[ax].offset[7:0] <= wr_i.data;
          end
          if (wr_i.addr == HIGH_A) begin
            cal_o[ax].offset[14:8] <= wr_i.data[6:0];
            cal_o[ax].gain[8] <= wr_i.data[`GAIN_MSB_BIT];
          end
          if (wr_i.addr == GAIN_A) begin
            cal_o[ax].gain[7:0] <= wr_i.data;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== rtl/axis_offset_gain_calibration.sv
// Purpose: Per-axis offset and gain calibration with product identifier
// Assumes: Byte register port from the serial front end, one clock
// Notes: Corrected triplet updates together one cycle after sample_valid_i
//
// Function
// - Each axis holds signed fifteen-bit offset
// - Offset added before result reaches outputs
// - Reset values are per-chip factory trims
// - Software writes replace trims, used afterwards
// - X offset at 0x21 and 0x22
// - Y offset at 0x23 and 0x24
// - Z offset at 0x25 and 0x26
// - Gain nine bits, MSB in high bit7
// - X gain low byte at 0x27
// - Y gain 0x28, Z gain 0x29
// - Read-only identifier at 0x3B, bits3:1 factory
// - Results sign-extended sixteen bits, updated together
`timescale 1ns/1ns
`default_nettype none
`include "axis_cal_regs.svh"
module axis_offset_gain_calibration #(
  parameter logic [7:0] PART_ID_FIXED = `PART_ID_FIXED
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [2:0] part_trim_i,
  input wire axis_cal_pkg::axis_cal_t [2:0] trim_i,
  input wire logic sample_valid_i,
  input wire axis_cal_pkg::axis_triplet_t sample_i,
  output logic [7:0] reg_rdata_o,
  output logic result_valid_o,
  output axis_cal_pkg::axis_triplet_t result_o
);
  import axis_cal_pkg::*;

  // ********************************************
  // Declarations
  // ********************************************
  reg_wr_t wr; // Bundled write strobe
  axis_cal_t [2:0] cal; // Live calibration per axis
  axis_triplet_t next_result; // Combinational corrected triplet
  logic [2:0] part_bits; // Factory identifier bits, held
  logic rst_seen; // Reset in previous cycle
  logic [7:0] next_rdata; // Read mux

  assign wr = '{en: reg_wr_i, addr: reg_addr_i, data: reg_wdata_i};

  // Storage of offsets and gains
  axis_cal_bank u_bank (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .wr_i(wr),
    .trim_i(trim_i),
    .cal_o(cal)
  );

  // ********************************************
  // Correction per axis
  // ********************************************
  axis_corrector u_cx (
    .sample_i(sample_i.x),
    .cal_i(cal[0]),
    .result_o(next_result.x)
  );
  axis_corrector u_cy (
    .sample_i(sample_i.y),
    .cal_i(cal[1]),
    .result_o(next_result.y)
  );
  axis_corrector u_cz (
    .sample_i(sample_i.z),
    .cal_i(cal[2]),
    .result_o(next_result.z)
  );

  // All three axes land in the same edge
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      result_o <= '0;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= sample_valid_i;
      if (sample_valid_i) begin
        result_o <= next_result;
      end
    end
  end

  // ********************************************
  // Identifier factory bits
  // ********************************************
  // Trim pins caught after release, never under reset
  always_ff @(posedge sys_clk_i) begin
    rst_seen <= srst_i;
    if (srst_i) begin
      part_bits <= 3'h0;
    end else if (rst_seen) begin
      part_bits <= part_trim_i;
    end
  end

  // ********************************************
  // Read port
  // ********************************************
  // Calibration locations are write-only, so only the identifier reads
  always_comb begin
    next_rdata = `UNMAPPED_READ;
    if (reg_addr_i == `ADDR_PART_IDENTIFIER) begin
      next_rdata = PART_ID_FIXED;
      next_rdata[`PART_ID_FACTORY_MSB:`PART_ID_FACTORY_LSB] = part_bits;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ********************************************
  // Checks
  // ********************************************
  chk_result_update: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    sample_valid_i |=> result_valid_o && result_o == $past(next_result))
    else $error("result not updated from sample");
  chk_result_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !sample_valid_i |=> $stable(result_o))
    else $error("result changed without sample");
  chk_xlow_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    reg_wr_i && reg_addr_i == `ADDR_X_OFFSET_LOW && !rst_seen
    |=> cal[0].offset[7:0] == $past(reg_wdata_i))
    else $error("x offset low not written");
  chk_yhigh_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    reg_wr_i && reg_addr_i == `ADDR_Y_OFFSET_HIGH_GAIN_MSB && !rst_seen
    |=> cal[1].offset[14:8] == $past(reg_wdata_i[6:0])
      && cal[1].gain[8] == $past(reg_wdata_i[7]))
    else $error("y offset high or gain msb wrong");
  chk_zlow_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    reg_wr_i && reg_addr_i == `ADDR_Z_OFFSET_LOW && !rst_seen
    |=> cal[2].offset[7:0] == $past(reg_wdata_i))
    else $error("z offset low not written");
  chk_x_axis_gain_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    reg_wr_i && reg_addr_i == `ADDR_X_GAIN_LOW && !rst_seen
    |=> cal[0].gain[7:0] == $past(reg_wdata_i))
    else $error("x gain low not written");
  chk_z_axis_gain_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    reg_wr_i && reg_addr_i == `ADDR_Z_GAIN_LOW && !rst_seen
    |=> cal[2].gain[7:0] == $past(reg_wdata_i))
    else $error("z gain low not written");
  chk_trim_load: assert property (@(posedge sys_clk_i)
    $fell(srst_i) |=> cal == $past(trim_i))
    else $error("factory trims not loaded");
  chk_part_read: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    reg_rd_i && reg_addr_i == `ADDR_PART_IDENTIFIER
    |=> reg_rdata_o[7:4] == PART_ID_FIXED[7:4]
      && reg_rdata_o[0] == PART_ID_FIXED[0])
    else $error("identifier fixed bits wrong");
  chk_unity_gain: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    sample_valid_i && cal[0].gain == `GAIN_UNITY && cal[0].offset == 15'h0
    |=> result_o.x == $past(sample_i.x))
    else $error("unity gain changed sample");
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: Self-checking bench of the axis calibration bank
// Assumes: Gain 0x100 is unity, trims load on first edge after reset
// Notes: Expected results come from a local model of the written bytes
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import axis_cal_pkg::*;
  // Arbitrary fixed identifier bits, non-zero so their position shows
  localparam logic [7:0] ID_FIXED = 8'hA1;
  logic sys_clk_i = 1'b0; // 100 ns period
  logic srst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [6:0] reg_addr_i = 7'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [2:0] part_trim_i = 3'h0;
  axis_cal_t [2:0] trim_i = '0;
  logic sample_valid_i = 1'b0;
  axis_triplet_t sample_i = '0;
  logic [7:0] reg_rdata_o;
  logic result_valid_o;
  axis_triplet_t result_o;
  int errors = 0;
  int tests_run = 0;
  logic [14:0] moff [3]; // Model of the offsets, 0=x
  logic [8:0] mgain [3]; // Model of the gains

  axis_offset_gain_calibration #(.PART_ID_FIXED(ID_FIXED))
      u_axis_offset_gain_calibration (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .part_trim_i(part_trim_i),
    .trim_i(trim_i), .sample_valid_i(sample_valid_i),
    .sample_i(sample_i), .reg_rdata_o(reg_rdata_o),
    .result_valid_o(result_valid_o), .result_o(result_o));

  always #50 sys_clk_i = ~sys_clk_i;

  // ****************************************
  // Shared tasks
  // ****************************************
  // Scale, shift, add offset, then clamp to 16 bits
  function automatic logic [15:0] corr(logic [15:0] s, int i);
    int p;
    p = ($signed(s) * int'(mgain[i])) >>> 8;
    p = p + int'($signed(moff[i]));
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return p[15:0];
  endfunction

  task automatic check(bit ok, string msg);
    tests_run++;
    if (!ok) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // One byte write, then mirror it into the model
  task automatic wr(logic [6:0] a, logic [7:0] d);
    int i;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    if (a >= 7'h21 && a <= 7'h26) begin
      i = int'(a - 7'h21) / 2;
      if (a[0]) begin
        moff[i][7:0] = d; // Low byte at odd address
      end else begin
        moff[i][14:8] = d[6:0];
        mgain[i][8] = d[7]; // Gain top bit shares the high byte
      end
    end else if (a >= 7'h27 && a <= 7'h29) begin
      mgain[int'(a - 7'h27)][7:0] = d;
    end
  endtask

  task automatic rd(logic [6:0] a, logic [7:0] e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o === e, "read data mismatch");
  endtask

  // One raw triplet in, corrected triplet one cycle later
  task automatic smp(logic [15:0] x, logic [15:0] y, logic [15:0] z);
    axis_triplet_t e;
    e = {corr(x, 0), corr(y, 1), corr(z, 2)};
    @(posedge sys_clk_i);
    sample_valid_i <= 1'b1;
    sample_i <= {x, y, z};
    @(posedge sys_clk_i);
    sample_valid_i <= 1'b0;
    #1 check(result_valid_o === 1'b1, "result strobe missing");
    check(result_o === e, "corrected triplet mismatch");
    @(posedge sys_clk_i);
    #1 check(result_valid_o === 1'b0, "result strobe too long");
  endtask

  // Reset with given factory trims; they load on first edge after
  task automatic do_reset(axis_cal_t [2:0] t, logic [2:0] p);
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    trim_i <= t;
    part_trim_i <= p;
    repeat (3) @(posedge sys_clk_i);
    #1 check(result_valid_o === 1'b0, "strobe during reset");
    check(reg_rdata_o === 8'h00, "read data during reset");
    @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    for (int i = 0; i < 3; i++) begin
      moff[i] = t[i].offset;
      mgain[i] = t[i].gain;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Trims alone correct samples: signed offset, half gain
  task automatic t_trim_load();
    do_reset({{15'h0000, 9'h080}, {15'h7FF0, 9'h100},
              {15'h0010, 9'h100}}, 3'b101);
    smp(16'h0100, 16'h0000, 16'h0200);
  endtask

  // Every byte written; extremes force sign and clamp paths
  task automatic t_reg_write();
    wr(7'h21, 8'h23);
    wr(7'h22, 8'hC1);
    wr(7'h27, 8'h00);
    wr(7'h23, 8'h00);
    wr(7'h24, 8'h40);
    wr(7'h28, 8'hFF);
    wr(7'h25, 8'hFF);
    wr(7'h26, 8'hBF);
    wr(7'h29, 8'hFF);
    smp(16'h8000, 16'h7FFF, 16'h7FFF);
    // High byte alone: gain top bit cleared, low bytes kept
    wr(7'h22, 8'h01);
    smp(16'h1234, 16'hFF00, 16'hC000);
  endtask

  // Identifier layout, write-only reads and ignored writes
  task automatic t_reads();
    rd(7'h3B, {ID_FIXED[7:4], 3'b101, ID_FIXED[0]});
    // Host view: factory bits masked off, fixed bits alone compared
    check((reg_rdata_o & 8'hF1) === (ID_FIXED & 8'hF1), "id mask");
    wr(7'h3B, 8'hFF);
    wr(7'h2A, 8'h55);
    rd(7'h3B, {ID_FIXED[7:4], 3'b101, ID_FIXED[0]});
    rd(7'h21, 8'h00);
    rd(7'h40, 8'h00);
    smp(16'h0001, 16'h0002, 16'h0003);
  endtask

  // Second reset restores new trims over software values
  task automatic t_reset_again();
    do_reset({{15'h4000, 9'h1FF}, {15'h3FFF, 9'h000},
              {15'h0001, 9'h101}}, 3'b010);
    rd(7'h3B, {ID_FIXED[7:4], 3'b010, ID_FIXED[0]});
    smp(16'hFFFF, 16'h8000, 16'h4000);
  endtask

  task automatic tally_and_finish();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run is about 61 cycles; allow about eighty times that
  initial begin
    #500000;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    t_trim_load();
    t_reg_write();
    t_reads();
    t_reset_again();
    tally_and_finish();
  end
endmodule
`default_nettype wire
